// file: design/pirs_pkg.sv
// Constants for the parallel interrupt route select block
package pirs_pkg;
	// Index register slots and the data port address
	localparam logic [2:0] IDX_PAR_ROUTE = 3'h4;
	localparam logic [2:0] IDX_VERSION = 3'h6;
	localparam logic [2:0] IDX_SER0_ROUTE = 3'h2;
	localparam logic [2:0] IDX_SER1_ROUTE = 3'h3;
	localparam logic [2:0] ADDR_DATA_PORT = 3'h7;
	localparam logic [2:0] ADDR_INDEX = 3'h0;
	// Field layout
	localparam int SEL_MSB = 3;
	localparam logic [7:0] ROUTE_RESET = 8'h00;
	localparam logic [3:0] RESERVED_ZERO = 4'h0;
	// Select codes
	localparam logic [3:0] SEL_OFF = 4'h0;
	localparam logic [3:0] SEL_IRQ3 = 4'h1;
	localparam logic [3:0] SEL_IRQ4 = 4'h2;
	localparam logic [3:0] SEL_IRQ5 = 4'h3;
	localparam logic [3:0] SEL_IRQ6 = 4'h4;
	localparam logic [3:0] SEL_IRQ7 = 4'h5;
	localparam logic [3:0] SEL_IRQ10 = 4'h6;
	localparam logic [3:0] SEL_IRQ11 = 4'h7;
	localparam logic [3:0] SEL_ROM = 4'h8;
	localparam logic [3:0] SEL_IRQ15 = 4'h9;
	localparam int NUM_LINES = 9;
	// Select code 1..9 of each mux line index
	localparam logic [3:0] LINE_CODE [NUM_LINES] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5,
		4'h6, 4'h7, 4'h8, 4'h9};
	// Arbitrary revision value; output is its ones-complement
	localparam logic [7:0] SILICON_REV = 8'h05;
endpackage

// file: design/pirs_route.sv
// Parallel interrupt routing onto the interrupt mux inputs, plus version register
//
// Overview of operation
// - Four-bit code picks which mux input parallel replaces
// - Parallel wins over serial on shared input
// - Conflict substitutes winner, never ORs sources
// - Version register reads ones-complement revision, read-only
// - Version reached via index 6, address 7
// - All three selects stop oscillator, pull-ups
// - Routing register reached via index 4, address 7
// - Upper nibble reserved zero; clears on reset
`timescale 1ns/1ps
module pirs_route (
	// Clock and reset
	input wire logic REF_CLK,
	input wire logic RST_N,
	// Host register port
	input wire logic CHIP_SEL_N,
	input wire logic [2:0] ADDR,
	input wire logic WR_STB,
	input wire logic RD_STB,
	input wire logic [7:0] WDATA,
	output logic [7:0] RDATA,
	// Chip select pins
	input wire logic CHIP_SELECT_ZERO,
	input wire logic CHIP_SELECT_ONE,
	input wire logic CHIP_SELECT_TWO,
	// Interrupt sources and enables
	input wire logic PAR_IRQ,
	input wire logic PARALLEL_IRQ_OUTPUT_ENABLE,
	input wire logic SER0_IRQ,
	input wire logic [3:0] SER0_SEL,
	input wire logic SER1_IRQ,
	input wire logic [3:0] SER1_SEL,
	// External pins, order IRQ3..7,10,11,rom sense,15
	input wire logic [8:0] PIN_IRQ,
	// Mux inputs after substitution
	output logic [8:0] MUX_IN,
	// Power control
	output logic OSC_EN,
	output logic PULLUP_EN
);
	// Synchronised pins
	logic [8:0] pin_s1_q, pin_s2_q;
	logic [2:0] cs_s1_q, cs_s2_q;
	logic par_s1_q, par_s2_q, s0_s1_q, s0_s2_q, s1_s1_q, s1_s2_q;
	// Register state
	logic [2:0] index_q, index_d;
	logic [7:0] route_q, route_d;
	logic [7:0] rdata_q, rdata_d;
	logic [8:0] mux_q, mux_d;
	logic power_on_q, power_on_d;
	logic hit_data, all_cs;

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			pin_s1_q <= 9'h000;
			pin_s2_q <= 9'h000;
			cs_s1_q <= 3'h0;
			cs_s2_q <= 3'h0;
			par_s1_q <= 1'b0;
			par_s2_q <= 1'b0;
			s0_s1_q <= 1'b0;
			s0_s2_q <= 1'b0;
			s1_s1_q <= 1'b0;
			s1_s2_q <= 1'b0;
		end else begin
			pin_s1_q <= PIN_IRQ;
			pin_s2_q <= pin_s1_q;
			cs_s1_q <= {CHIP_SELECT_TWO, CHIP_SELECT_ONE, CHIP_SELECT_ZERO};
			cs_s2_q <= cs_s1_q;
			par_s1_q <= PAR_IRQ;
			par_s2_q <= par_s1_q;
			s0_s1_q <= SER0_IRQ;
			s0_s2_q <= s0_s1_q;
			s1_s1_q <= SER1_IRQ;
			s1_s2_q <= s1_s1_q;
		end
	end

	// Host port and serial selects share this clock, so no synchroniser
	assign hit_data = !CHIP_SEL_N && (ADDR == pirs_pkg::ADDR_DATA_PORT);
	assign all_cs = &cs_s2_q;

	always_comb begin
		index_d = index_q;
		route_d = route_q;
		rdata_d = rdata_q;
		if (!CHIP_SEL_N && WR_STB && ADDR == pirs_pkg::ADDR_INDEX) begin
			index_d = WDATA[2:0];
		end
		if (hit_data && WR_STB && index_q == pirs_pkg::IDX_PAR_ROUTE) begin
			route_d = {pirs_pkg::RESERVED_ZERO, WDATA[pirs_pkg::SEL_MSB:0]};
		end
		if (hit_data && RD_STB) begin
			case (index_q)
				pirs_pkg::IDX_PAR_ROUTE: rdata_d = route_q;
				pirs_pkg::IDX_VERSION: rdata_d = ~pirs_pkg::SILICON_REV;
				default: rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			index_q <= 3'h0;
			route_q <= pirs_pkg::ROUTE_RESET;
			rdata_q <= 8'h00;
		end else begin
			index_q <= index_d;
			route_q <= route_d;
			rdata_q <= rdata_d;
		end
	end

	// Host port checks; the index survives data port traffic
	a_index_write: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		(!CHIP_SEL_N && WR_STB && ADDR == pirs_pkg::ADDR_INDEX)
		|=> index_q == $past(WDATA[2:0]))
		else $error("index register write not taken");
	a_index_keep: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		!(!CHIP_SEL_N && WR_STB && ADDR == pirs_pkg::ADDR_INDEX) |=> $stable(index_q))
		else $error("index register changed without a write");
	a_route_read: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		(hit_data && RD_STB && index_q == pirs_pkg::IDX_PAR_ROUTE)
		|=> RDATA == $past(route_q))
		else $error("routing register read wrong");
	a_route_hold: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		!(hit_data && WR_STB && index_q == pirs_pkg::IDX_PAR_ROUTE) |=> $stable(route_q))
		else $error("routing register changed without a write");
	a_rdata_hold: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		!(hit_data && RD_STB) |=> $stable(RDATA))
		else $error("read data changed without a read");

	// Per-line substitution; priority parallel, serial 1, serial 0
	// Reserved codes match no line, so such a write routes nowhere
	generate
		for (genvar i = 0; i < pirs_pkg::NUM_LINES; i++) begin : g_line
			always_comb begin
				if (route_q[pirs_pkg::SEL_MSB:0] == pirs_pkg::LINE_CODE[i]) begin
					mux_d[i] = par_s2_q;
				end else if (SER1_SEL == pirs_pkg::LINE_CODE[i]) begin
					mux_d[i] = s1_s2_q;
				end else if (SER0_SEL == pirs_pkg::LINE_CODE[i]) begin
					mux_d[i] = s0_s2_q;
				end else begin
					mux_d[i] = pin_s2_q[i];
				end
			end

			a_line_par: assert property (@(posedge REF_CLK) disable iff (!RST_N)
				route_q[pirs_pkg::SEL_MSB:0] == pirs_pkg::LINE_CODE[i]
				|=> MUX_IN[i] == $past(par_s2_q))
				else $error("parallel interrupt not on its line");
			a_line_subst: assert property (@(posedge REF_CLK) disable iff (!RST_N)
				(route_q[pirs_pkg::SEL_MSB:0] == pirs_pkg::LINE_CODE[i] && !par_s2_q
				&& (SER0_SEL == pirs_pkg::LINE_CODE[i]
				|| SER1_SEL == pirs_pkg::LINE_CODE[i])) |=> !MUX_IN[i])
				else $error("serial interrupt mixed onto parallel line");
			a_line_pass: assert property (@(posedge REF_CLK) disable iff (!RST_N)
				(route_q[pirs_pkg::SEL_MSB:0] != pirs_pkg::LINE_CODE[i]
				&& SER0_SEL != pirs_pkg::LINE_CODE[i]
				&& SER1_SEL != pirs_pkg::LINE_CODE[i]) |=> MUX_IN[i] == $past(pin_s2_q[i]))
				else $error("unselected line altered");
		end
	endgenerate

	// Oscillator and pull-ups follow the chip select combination
	assign power_on_d = !all_cs;

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			mux_q <= 9'h000;
			power_on_q <= 1'b1;
		end else begin
			mux_q <= mux_d;
			power_on_q <= power_on_d;
		end
	end

	a_osc_run: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		!all_cs |=> OSC_EN && PULLUP_EN)
		else $error("oscillator stopped without all selects");

	assign RDATA = rdata_q;
	assign MUX_IN = mux_q;
	assign OSC_EN = power_on_q;
	assign PULLUP_EN = power_on_q;

	// Enable input is the software's duty; logic ignores it and never gates the parallel interrupt
	logic unused_en;
	assign unused_en = PARALLEL_IRQ_OUTPUT_ENABLE;

	a_route_write: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		(hit_data && WR_STB && index_q == pirs_pkg::IDX_PAR_ROUTE)
		|=> route_q == {4'h0, $past(WDATA[3:0])})
		else $error("routing register write not taken");
	a_route_resv: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		route_q[7:4] == 4'h0)
		else $error("reserved routing bits not zero");
	a_version_read: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		(hit_data && RD_STB && index_q == pirs_pkg::IDX_VERSION)
		|=> RDATA == ~pirs_pkg::SILICON_REV)
		else $error("version read wrong");
	a_version_ro: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		(hit_data && WR_STB && index_q == pirs_pkg::IDX_VERSION) |=> $stable(route_q))
		else $error("version write had effect");
	a_par_wins: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		(route_q[3:0] == pirs_pkg::SEL_IRQ4 && $stable(route_q)) |=> MUX_IN[1] == $past(par_s2_q))
		else $error("parallel did not win");
	a_no_or: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		(route_q[3:0] == pirs_pkg::SEL_IRQ3 && SER0_SEL == pirs_pkg::SEL_IRQ3 && !par_s2_q
		&& $stable(route_q)) |=> !MUX_IN[0])
		else $error("sources were ORed");
	a_pin_pass: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		(route_q[3:0] == pirs_pkg::SEL_OFF && SER0_SEL == 4'h0 && SER1_SEL == 4'h0
		&& $stable(route_q)) |=> MUX_IN == $past(pin_s2_q))
		else $error("unselected pins altered");
	a_osc_stop: assert property (@(posedge REF_CLK) disable iff (!RST_N)
		all_cs |=> !OSC_EN && !PULLUP_EN)
		else $error("oscillator not stopped");
endmodule

// file: sim/pirs_sysctl.sv
// Far-side model: holds the interrupt pins and samples the mux inputs
`timescale 1ns/1ps
module pirs_sysctl (
	// Clock
	input wire logic clk,
	// Pin levels from the bench, mux inputs seen
	input wire logic [8:0] drive,
	input wire logic [8:0] mux_in,
	output logic [8:0] pin_irq,
	output logic [8:0] seen
);
	// Pins never float, so no settled unknown can mask a fault
	assign pin_irq = drive;
	always_ff @(posedge clk) begin
		seen <= mux_in;
	end
endmodule

// file: sim/tb_parallel_irq_route_select.sv
// Testbench for the parallel interrupt route select block
`timescale 1ns/1ps
module tb_parallel_irq_route_select;
	logic clk = 0, rst_n = 0, cs_n = 1, wr = 0, rd = 0, par = 0, ser = 0;
	logic c0 = 0, c1 = 0, c2 = 0, en = 1, ser1 = 0;
	logic [2:0] addr = 3'h0;
	logic [7:0] wdata = 8'h00, rdata;
	logic [3:0] sel = 4'h0, sel1 = 4'h0;
	logic [8:0] drive = 9'h000, pins, mux, seen, e;
	logic osc, pu;
	logic [15:0] rnd = 16'hfaa5;
	logic [7:0] exp_q[$];
	int err_count = 0, num_checks = 0;
	always #20 clk = ~clk;
	function automatic logic [15:0] lfsr_next(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	pirs_route i_pirs_route(.REF_CLK(clk), .RST_N(rst_n), .CHIP_SEL_N(cs_n), .ADDR(addr),
		.WR_STB(wr), .RD_STB(rd), .WDATA(wdata), .RDATA(rdata), .CHIP_SELECT_ZERO(c0),
		.CHIP_SELECT_ONE(c1), .CHIP_SELECT_TWO(c2), .PAR_IRQ(par),
		.PARALLEL_IRQ_OUTPUT_ENABLE(en), .SER0_IRQ(ser), .SER0_SEL(sel), .SER1_IRQ(ser1),
		.SER1_SEL(sel1), .PIN_IRQ(pins), .MUX_IN(mux), .OSC_EN(osc), .PULLUP_EN(pu));
	pirs_sysctl i_pirs_sysctl(.clk(clk), .drive(drive), .mux_in(mux), .pin_irq(pins),
		.seen(seen));
	task automatic check(input string n, input logic [8:0] x, input logic [8:0] s);
		num_checks++;
		if (s !== x) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", n, x, s);
		end
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic access(input logic w, input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		#1;
		cs_n = 0;
		addr = a;
		wdata = d;
		wr = w;
		rd = !w;
		@(posedge clk);
		#1;
		cs_n = 1;
		wr = 0;
		rd = 0;
	endtask
	task automatic rd_reg(input logic [2:0] idx, input logic [7:0] x);
		access(1, pirs_pkg::ADDR_INDEX, {5'h00, idx});
		exp_q.push_back(x);
		access(0, pirs_pkg::ADDR_DATA_PORT, 8'h00);
	endtask
	task automatic cs_pins(input logic [2:0] v, input logic [8:0] x);
		{c2, c1, c0} = v;
		repeat (4) @(posedge clk);
		#1;
		check("power", x, {7'h00, pu, osc});
	endtask
	// Read result lands on the taking edge; checked 5 ns after it
	always @(posedge clk) if (rd && !cs_n && addr === pirs_pkg::ADDR_DATA_PORT) begin
		#5;
		check("rdata", {1'b0, exp_q.pop_front()}, {1'b0, rdata});
	end
	initial begin
		#200000;
		err_count++;
		give_verdict();
	end
	initial begin
		repeat (3) @(posedge clk);
		#1 rst_n = 1;
		check("power", 9'h003, {7'h00, pu, osc});
		rd_reg(pirs_pkg::IDX_PAR_ROUTE, pirs_pkg::ROUTE_RESET);
		access(1, pirs_pkg::ADDR_INDEX, 8'h06);
		access(1, pirs_pkg::ADDR_DATA_PORT, 8'h3c);
		rd_reg(pirs_pkg::IDX_VERSION, ~pirs_pkg::SILICON_REV);
		$display("test version done");
		// Only defined codes; both serial sources share the input and oppose the parallel level
		for (int c = 0; c < 10; c++) begin
			access(1, pirs_pkg::ADDR_INDEX, {5'h00, pirs_pkg::IDX_PAR_ROUTE});
			access(1, pirs_pkg::ADDR_DATA_PORT, {4'h0, 4'(c)});
			rd_reg(pirs_pkg::IDX_PAR_ROUTE, {4'h0, 4'(c)});
			rnd = lfsr_next(rnd);
			drive = rnd[8:0];
			par = rnd[9];
			ser = !rnd[9];
			ser1 = !rnd[9];
			sel = 4'(c);
			sel1 = 4'(c);
			repeat (5) @(posedge clk);
			#1;
			e = drive;
			if (c > 0) e[c - 1] = par;
			check("mux", e, seen);
		end
		$display("test routing done");
		// Parallel beats serial 0 on IRQ3; serial 1 beats serial 0 on IRQ4
		access(1, pirs_pkg::ADDR_INDEX, {5'h00, pirs_pkg::IDX_PAR_ROUTE});
		access(1, pirs_pkg::ADDR_DATA_PORT, {4'h0, pirs_pkg::SEL_IRQ3});
		par = 0;
		ser = 1;
		ser1 = 1;
		sel = pirs_pkg::SEL_IRQ3;
		sel1 = pirs_pkg::SEL_IRQ4;
		repeat (5) @(posedge clk);
		#1;
		e = drive;
		e[0] = 1'b0;
		e[1] = 1'b1;
		check("subst", e, seen);
		ser1 = 0;
		sel = pirs_pkg::SEL_IRQ4;
		repeat (5) @(posedge clk);
		#1;
		e[1] = 1'b0;
		check("serial", e, seen);
		$display("test substitution done");
		cs_pins(3'b011, 9'h003);
		cs_pins(3'b111, 9'h000);
		cs_pins(3'b110, 9'h003);
		$display("test power done");
		give_verdict();
	end
endmodule
